// ---- hdl/branch_target.sv ----
// Branch destination forming for relative, page, long and indirect jumps
`timescale 1ns/1ps
module branch_target (
    input wire decode_pkg::instr_s instr,
    input wire logic [15:0] data_pointer,
    input wire logic [7:0] acc,
    output logic [15:0] target,
    output logic has_target
);
    logic [7:0] rel;
    logic [7:0] op;

    always_comb
    begin
        op = instr.opcode;
        // Three-byte branches carry the offset in the last byte
        rel = (op[3:0] == 4'h0 && op[7:4] < 4'h4) || op[7:4] == 4'hB || op == decode_pkg::OP_DECREMENT_JUMP_NONZERO_D
            ? instr.op2 : instr.op1;
        has_target = 1'b1;
        if (op[3:0] == 4'h1)
            target = {instr.next_pc[15:decode_pkg::PAGE_BITS], op[7:5], instr.op1};
        else if (op == decode_pkg::OP_LJMP || op == decode_pkg::OP_LONG_CALL)
            target = {instr.op1, instr.op2};
        else if (op == decode_pkg::OP_JMP_ADP)
            target = data_pointer + {8'h00, acc};
        else
        begin
            // Sign extension keeps backward offsets inside the 16-bit space
            target = instr.next_pc + {{8{rel[decode_pkg::REL_MSB]}}, rel};
            has_target = (op[3:0] == 4'h0 && op[7:4] <= 4'h8 && op != decode_pkg::OP_NOP)
                || op[7:4] == 4'hB && op[3:0] >= 4'h4 || op[7:4] == 4'hD && op[3] == 1'b1
                || op == decode_pkg::OP_DECREMENT_JUMP_NONZERO_D;
        end
    end
endmodule

// ---- hdl/decode_pkg.sv ----
// Shared types and constants for the instruction timing decoder
// How it works
// - Relative branch offset is signed 8-bit, added to next instruction address.
// - Page target keeps the next instruction's 2K page, low 11 bits from opcode top three bits and first operand.
// - Long target is a full 16-bit address anywhere in program space.
// - Unused opcode acts as no-operation; no-operation is one byte, one cycle.
// - Direct address below upper half is data RAM, upper half is special registers.
// - Indirect pointer operand uses only register 0 or 1 of current bank.
// - Bank register operand is one of eight, chosen by opcode, in current bank.
// - Exclusive-OR and other logic ops with bank register: one byte, one cycle.
// - Exclusive-OR with indirect RAM: one byte, two cycles.
// - AND immediate into direct byte: three bytes, three cycles.
// - Rotate accumulator left through carry: one byte, one cycle.
// - Increment data pointer: one byte, one cycle.
// - Load data pointer with 16-bit constant: three bytes, three cycles.
// - Code byte move at accumulator plus data pointer: one byte, three cycles.
// - Every external data move: one byte, three cycles.
// - Nibble exchange swaps low nibbles only: one byte, two cycles.
// - Jump on carry: two bytes, two cycles not taken, three taken.
// - Test-clear-jump: three bytes, three or four cycles, clears a set bit.
// - Compare-jump-unequal on indirect RAM: three bytes, four or five cycles.
// - Decrement-jump-nonzero on bank register: two bytes, two or three cycles.
// - Long call: three bytes, four cycles.
// - Subroutine return and interrupt return: one byte, five cycles each.
// - Conditional branch uses smaller count untaken, larger count taken.
package decode_pkg;

    typedef struct packed {
        logic [1:0] len;
        logic [2:0] cyc;
        logic cond;
    } timing_s;

    // Length, untaken cycles, conditional flag; a taken branch costs one more
    localparam timing_s T_1_1 = '{len: 2'h1, cyc: 3'h1, cond: 1'b0};
    localparam timing_s T_1_2 = '{len: 2'h1, cyc: 3'h2, cond: 1'b0};
    localparam timing_s T_1_3 = '{len: 2'h1, cyc: 3'h3, cond: 1'b0};
    localparam timing_s T_1_5 = '{len: 2'h1, cyc: 3'h5, cond: 1'b0};
    localparam timing_s T_2_2 = '{len: 2'h2, cyc: 3'h2, cond: 1'b0};
    localparam timing_s T_2_3 = '{len: 2'h2, cyc: 3'h3, cond: 1'b0};
    localparam timing_s T_3_3 = '{len: 2'h3, cyc: 3'h3, cond: 1'b0};
    localparam timing_s T_3_4 = '{len: 2'h3, cyc: 3'h4, cond: 1'b0};
    localparam timing_s T_2_2C = '{len: 2'h2, cyc: 3'h2, cond: 1'b1};
    localparam timing_s T_3_3C = '{len: 2'h3, cyc: 3'h3, cond: 1'b1};
    localparam timing_s T_3_4C = '{len: 2'h3, cyc: 3'h4, cond: 1'b1};

    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_SPARE = 8'hA5;
    localparam logic [7:0] OP_JBC = 8'h10;
    localparam logic [7:0] OP_JC = 8'h40;
    localparam logic [7:0] OP_JNC = 8'h50;
    localparam logic [7:0] OP_JZ = 8'h60;
    localparam logic [7:0] OP_JNZ = 8'h70;
    localparam logic [7:0] OP_SJMP = 8'h80;
    localparam logic [7:0] OP_LJMP = 8'h02;
    localparam logic [7:0] OP_LONG_CALL = 8'h12;
    localparam logic [7:0] OP_RET = 8'h22;
    localparam logic [7:0] OP_IRET = 8'h32;
    localparam logic [7:0] OP_RLC = 8'h33;
    localparam logic [7:0] OP_ANL_DI = 8'h53;
    localparam logic [7:0] OP_JMP_ADP = 8'h73;
    localparam logic [7:0] OP_LD_DATA_POINTER = 8'h90;
    localparam logic [7:0] OP_CODE_DP = 8'h93;
    localparam logic [7:0] OP_INC_DATA_POINTER = 8'hA3;
    localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_AI = 8'hB4;
    localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_AD = 8'hB5;
    localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO_D = 8'hD5;
    localparam logic [7:0] OP_NIBX = 8'hD6;
    localparam logic [7:0] OP_XMOV_RD = 8'hE0;

    localparam int REL_MSB = 7;
    localparam int PAGE_BITS = 11;
    localparam int SFR_BIT = 7;
    localparam logic [7:0] DECREMENT_JUMP_NONZERO_LAST = 8'h01;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [15:0] next_pc;
    } instr_s;

    typedef struct packed {
        logic carry;
        logic bit_val;
        logic [7:0] acc;
        logic [7:0] reg_val;
        logic [7:0] ind_val;
        logic [7:0] dir_val;
        logic [15:0] data_pointer;
    } cond_s;

    typedef struct packed {
        logic [7:0] bank_register;
        logic [7:0] indirect_pointer_operand;
        logic [7:0] direct_addr;
        logic direct_is_sfr;
    } operand_s;

endpackage

// ---- hdl/instr_timing.sv ----
// Instruction length, cycle timing and branch decision sequencer
`timescale 1ns/1ps
module instr_timing (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Instruction issue
    input wire logic ISSUE,
    input wire decode_pkg::instr_s INSTR,
    input wire decode_pkg::cond_s COND,
    input wire logic [1:0] BANK,
    input wire logic [7:0] PTR0,
    input wire logic [7:0] PTR1,
    output logic READY,
    // Decoded result
    output logic [1:0] LENGTH,
    output logic [2:0] CYCLES,
    output logic TAKEN,
    output logic [15:0] TARGET,
    output logic TARGET_VALID,
    output decode_pkg::operand_s OPER,
    output logic CLEAR_BIT,
    output logic [7:0] NIB_ACC,
    output logic [7:0] NIB_RAM,
    output logic RETIRE
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_e;

    state_e state_q;
    logic [2:0] cnt_q;
    logic [2:0] el_q;
    logic take;
    logic go;
    logic has_tgt;
    logic [15:0] tgt;
    logic [2:0] cyc_eff;
    decode_pkg::timing_s tm;
    decode_pkg::operand_s oper_c;
    logic [7:0] op;

    // Table lookup by opcode, used only by the issue logic
    function automatic decode_pkg::timing_s timing_of(input logic [7:0] o);
        timing_of = decode_pkg::T_2_2;
        case (o[3:0])
            4'h0:
                case (o[7:4])
                    4'h0: timing_of = decode_pkg::T_1_1;
                    4'h1, 4'h2, 4'h3: timing_of = decode_pkg::T_3_3C;
                    4'h4, 4'h5, 4'h6, 4'h7: timing_of = decode_pkg::T_2_2C;
                    4'h8: timing_of = decode_pkg::T_2_3;
                    4'h9: timing_of = decode_pkg::T_3_3;
                    4'hE, 4'hF: timing_of = decode_pkg::T_1_3;
                    default: timing_of = decode_pkg::T_2_2;
                endcase
            4'h1: timing_of = decode_pkg::T_2_3;
            4'h2:
                case (o[7:4])
                    4'h0, 4'h1: timing_of = decode_pkg::T_3_4;
                    4'h2, 4'h3: timing_of = decode_pkg::T_1_5;
                    4'hE, 4'hF: timing_of = decode_pkg::T_1_3;
                    default: timing_of = decode_pkg::T_2_2;
                endcase
            4'h3:
                case (o[7:4])
                    4'h4, 4'h5, 4'h6: timing_of = decode_pkg::T_3_3;
                    4'h7, 4'h8, 4'h9: timing_of = decode_pkg::T_1_3;
                    4'hE, 4'hF: timing_of = decode_pkg::T_1_3;
                    default: timing_of = decode_pkg::T_1_1;
                endcase
            4'h4:
                case (o[7:4])
                    4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: timing_of = decode_pkg::T_1_1;
                    4'hB: timing_of = decode_pkg::T_3_3C;
                    default: timing_of = decode_pkg::T_2_2;
                endcase
            4'h5:
                case (o[7:4])
                    4'h7, 4'h8: timing_of = decode_pkg::T_3_3;
                    4'hA: timing_of = decode_pkg::T_1_1;
                    4'hB, 4'hD: timing_of = decode_pkg::T_3_3C;
                    default: timing_of = decode_pkg::T_2_2;
                endcase
            4'h6, 4'h7:
                case (o[7:4])
                    4'h7, 4'h8, 4'hA: timing_of = decode_pkg::T_2_2;
                    4'hB: timing_of = decode_pkg::T_3_4C;
                    default: timing_of = decode_pkg::T_1_2;
                endcase
            default:
                case (o[7:4])
                    4'h7, 4'h8, 4'hA: timing_of = decode_pkg::T_2_2;
                    4'hB: timing_of = decode_pkg::T_3_3C;
                    4'hD: timing_of = decode_pkg::T_2_2C;
                    default: timing_of = decode_pkg::T_1_1;
                endcase
        endcase
    endfunction

    operand_resolve u_oper (
        .opcode(INSTR.opcode),
        .op1(INSTR.op1),
        .bank(BANK),
        .ptr0(PTR0),
        .ptr1(PTR1),
        .oper(oper_c)
    );

    branch_target u_tgt (
        .instr(INSTR),
        .data_pointer(COND.data_pointer),
        .acc(COND.acc),
        .target(tgt),
        .has_target(has_tgt)
    );

    // Branch decision from conditions sampled in the issue cycle
    always_comb
    begin
        op = INSTR.opcode;
        tm = timing_of(op);
        take = 1'b0;
        case (op[7:4])
            4'h1, 4'h2: take = op[3:0] == 4'h0 && COND.bit_val;
            4'h3: take = op[3:0] == 4'h0 && !COND.bit_val;
            4'h4: take = op[3:0] == 4'h0 && COND.carry;
            4'h5: take = op[3:0] == 4'h0 && !COND.carry;
            4'h6: take = op[3:0] == 4'h0 && COND.acc == 8'h00;
            4'h7: take = op[3:0] == 4'h0 && COND.acc != 8'h00;
            4'hB:
                if (op == decode_pkg::OP_COMPARE_JUMP_UNEQUAL_AI)
                    take = COND.acc != INSTR.op1;
                else if (op == decode_pkg::OP_COMPARE_JUMP_UNEQUAL_AD)
                    take = COND.acc != COND.dir_val;
                else if (op[3:1] == 3'b011)
                    take = COND.ind_val != INSTR.op1;
                else
                    take = op[3] && COND.reg_val != INSTR.op1;
            4'hD:
                if (op[3])
                    take = COND.reg_val != decode_pkg::DECREMENT_JUMP_NONZERO_LAST;
                else
                    take = op == decode_pkg::OP_DECREMENT_JUMP_NONZERO_D && COND.dir_val != decode_pkg::DECREMENT_JUMP_NONZERO_LAST;
            default: take = 1'b0;
        endcase
        take = take && tm.cond;
        // Taken costs exactly one more cycle than untaken
        cyc_eff = take ? 3'(tm.cyc + 3'h1) : tm.cyc;
    end

    // Accept a new instruction when idle or in the retiring cycle
    assign READY = state_q == ST_IDLE || RETIRE;
    assign go = ISSUE && READY;
    assign RETIRE = state_q == ST_EXEC && cnt_q == 3'h1;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            state_q <= ST_IDLE;
        else if (go)
            state_q <= ST_EXEC;
        else if (RETIRE)
            state_q <= ST_IDLE;
    end

    // Count down in system clocks; no machine cycle prescaler
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            cnt_q <= 3'h0;
        else if (go)
            cnt_q <= cyc_eff;
        else if (state_q == ST_EXEC)
            cnt_q <= 3'(cnt_q - 3'h1);
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            LENGTH <= 2'h0;
            CYCLES <= 3'h0;
            TAKEN <= 1'b0;
            TARGET <= 16'h0000;
            TARGET_VALID <= 1'b0;
            OPER <= '0;
        end
        else if (go)
        begin
            LENGTH <= tm.len;
            CYCLES <= cyc_eff;
            TAKEN <= take;
            TARGET <= tgt;
            TARGET_VALID <= has_tgt && (take || !tm.cond);
            OPER <= oper_c;
        end
    end

    // Bit clear and nibble exchange side effects
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            CLEAR_BIT <= 1'b0;
            NIB_ACC <= 8'h00;
            NIB_RAM <= 8'h00;
        end
        else if (go)
        begin
            CLEAR_BIT <= op == decode_pkg::OP_JBC && COND.bit_val;
            if (op[7:1] == decode_pkg::OP_NIBX[7:1])
            begin
                NIB_ACC <= {COND.acc[7:4], COND.ind_val[3:0]};
                NIB_RAM <= {COND.ind_val[7:4], COND.acc[3:0]};
            end
        end
    end

    // Elapsed cycles since issue, read only by checks
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            el_q <= 3'h0;
        else if (go)
            el_q <= 3'h1;
        else if (state_q == ST_EXEC)
            el_q <= 3'(el_q + 3'h1);
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_issue(logic [7:0] o);
        go && INSTR.opcode == o;
    endsequence

    sequence s_result(logic [1:0] l, logic [2:0] c);
        LENGTH == l && CYCLES == c;
    endsequence

    a_retire_count: assert property (RETIRE |-> el_q == CYCLES)
        else $error("retire not at cycle count");
    a_nop_spare: assert property (s_issue(decode_pkg::OP_SPARE) |=> s_result(2'h1, 3'h1) and RETIRE)
        else $error("spare opcode not like nop");
    a_xor_reg: assert property (go && INSTR.opcode[7:3] == 5'h0D |=> s_result(2'h1, 3'h1))
        else $error("xor register timing");
    a_xor_ind: assert property (go && INSTR.opcode[7:1] == 7'h33 |=> s_result(2'h1, 3'h2) ##1 RETIRE)
        else $error("xor indirect timing");
    a_and_imm: assert property (s_issue(decode_pkg::OP_ANL_DI) |=> s_result(2'h3, 3'h3))
        else $error("and immediate direct timing");
    a_rotate_carry: assert property (s_issue(decode_pkg::OP_RLC) |=> s_result(2'h1, 3'h1))
        else $error("rotate carry timing");
    a_data_pointer_inc: assert property (s_issue(decode_pkg::OP_INC_DATA_POINTER) |=> s_result(2'h1, 3'h1))
        else $error("pointer increment timing");
    a_data_pointer_load: assert property (s_issue(decode_pkg::OP_LD_DATA_POINTER) |=> s_result(2'h3, 3'h3))
        else $error("pointer load timing");
    a_code_move: assert property (s_issue(decode_pkg::OP_CODE_DP) |=> s_result(2'h1, 3'h3))
        else $error("code byte move timing");
    a_ext_move: assert property (s_issue(decode_pkg::OP_XMOV_RD) |=> s_result(2'h1, 3'h3) ##2 RETIRE)
        else $error("external move timing");
    a_carry_jump: assert property (go && INSTR.opcode == decode_pkg::OP_JC
        |=> LENGTH == 2'h2 && CYCLES == (TAKEN ? 3'h3 : 3'h2) && TAKEN == $past(COND.carry))
        else $error("jump on carry timing");
    a_clear_jump: assert property (go && INSTR.opcode == decode_pkg::OP_JBC && COND.bit_val
        |=> CLEAR_BIT && TAKEN and s_result(2'h3, 3'h4))
        else $error("test clear jump");
    a_cmp_ind: assert property (go && INSTR.opcode[7:1] == 7'h5B
        |=> LENGTH == 2'h3 && CYCLES == (TAKEN ? 3'h5 : 3'h4))
        else $error("compare indirect timing");
    a_dec_jump: assert property (go && INSTR.opcode[7:3] == 5'h1B
        |=> LENGTH == 2'h2 && TAKEN == ($past(COND.reg_val) != 8'h01))
        else $error("decrement jump decision");
    a_long_call: assert property (s_issue(decode_pkg::OP_LONG_CALL) |=> s_result(2'h3, 3'h4)
        and TARGET == {$past(INSTR.op1), $past(INSTR.op2)})
        else $error("long call");
    a_returns: assert property (go && INSTR.opcode[7:5] == 3'h1 && INSTR.opcode[3:0] == 4'h2
        |=> s_result(2'h1, 3'h5) ##4 RETIRE)
        else $error("return timing");
    a_rel_target: assert property (s_issue(decode_pkg::OP_SJMP) |=> TARGET == 16'($past(INSTR.next_pc)
        + {{8{$past(INSTR.op1[7])}}, $past(INSTR.op1)}))
        else $error("relative target");
    a_page_target: assert property (go && INSTR.opcode[3:0] == 4'h1
        |=> TARGET[15:11] == $past(INSTR.next_pc[15:11]))
        else $error("page target");
    a_sfr_route: assert property (go |=> OPER.direct_is_sfr == $past(INSTR.op1[7]))
        else $error("direct space routing");
    a_nibble_keep: assert property (go && INSTR.opcode == decode_pkg::OP_NIBX
        |=> NIB_ACC[7:4] == $past(COND.acc[7:4]) && NIB_RAM[3:0] == $past(COND.acc[3:0]))
        else $error("nibble exchange");
endmodule

// ---- hdl/operand_resolve.sv ----
// Operand address resolution for register, indirect and direct forms
`timescale 1ns/1ps
module operand_resolve (
    input wire logic [7:0] opcode,
    input wire logic [7:0] op1,
    input wire logic [1:0] bank,
    input wire logic [7:0] ptr0,
    input wire logic [7:0] ptr1,
    output decode_pkg::operand_s oper
);
    always_comb
    begin
        oper.bank_register = {3'h0, bank, opcode[2:0]};
        oper.indirect_pointer_operand = opcode[0] ? ptr1 : ptr0;
        oper.direct_addr = op1;
        oper.direct_is_sfr = op1[decode_pkg::SFR_BIT];
    end
endmodule

// ---- tb/data_memory_model.sv ----
// Data memory and register bank model that supplies operand values to the core
`timescale 1ns/1ps
module data_memory_model (
    // Instruction being issued
    input wire decode_pkg::instr_s instr,
    // Core state
    input wire logic [1:0] bank,
    input wire logic carry,
    input wire logic bit_val,
    input wire logic [7:0] acc,
    input wire logic [15:0] data_pointer,
    // Values toward the core
    output decode_pkg::cond_s cond,
    output logic [7:0] ptr0,
    output logic [7:0] ptr1
);
    logic [7:0] ram [256];
    logic [7:0] ind_addr;

    // Address plus one in every byte, so a wrong pointer shows as a wrong value
    initial
    begin
        for (int i = 0; i < 256; i++)
            ram[i] = 8'(i + 1);
    end

    always_comb
    begin
        ptr0 = ram[{3'h0, bank, 3'h0}];
        ptr1 = ram[{3'h0, bank, 3'h1}];
        ind_addr = instr.opcode[0] ? ptr1 : ptr0;
        cond.carry = carry;
        cond.bit_val = bit_val;
        cond.acc = acc;
        cond.reg_val = ram[{3'h0, bank, instr.opcode[2:0]}];
        cond.ind_val = ram[ind_addr];
        // Upper half would be a special register; only the RAM half is modelled
        cond.dir_val = ram[instr.op1];
        cond.data_pointer = data_pointer;
    end
endmodule

// ---- tb/test_instr_timing.sv ----
// Self-checking testbench for the instruction timing decoder
`timescale 1ns/1ps
module test_instr_timing;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic ISSUE = 1'b0;
    decode_pkg::instr_s INSTR = '0;
    decode_pkg::cond_s COND;
    logic [1:0] BANK = 2'h0;
    logic [7:0] PTR0;
    logic [7:0] PTR1;
    logic carry = 1'b0;
    logic bit_val = 1'b0;
    logic [7:0] acc = 8'h00;
    logic [15:0] dp = 16'h0000;
    logic READY;
    logic [1:0] LENGTH;
    logic [2:0] CYCLES;
    logic TAKEN;
    logic [15:0] TARGET;
    logic TARGET_VALID;
    decode_pkg::operand_s OPER;
    logic CLEAR_BIT;
    logic [7:0] NIB_ACC;
    logic [7:0] NIB_RAM;
    logic RETIRE;
    int err_count = 0;
    int n_tests = 0;

    always #5 CLK = ~CLK;

    data_memory_model data_memory_model_inst (.instr(INSTR), .bank(BANK), .carry(carry),
        .bit_val(bit_val), .acc(acc), .data_pointer(dp), .cond(COND), .ptr0(PTR0), .ptr1(PTR1));

    instr_timing instr_timing_inst (.CLK(CLK), .RST_N(RST_N), .ISSUE(ISSUE), .INSTR(INSTR),
        .COND(COND), .BANK(BANK), .PTR0(PTR0), .PTR1(PTR1), .READY(READY), .LENGTH(LENGTH),
        .CYCLES(CYCLES), .TAKEN(TAKEN), .TARGET(TARGET), .TARGET_VALID(TARGET_VALID),
        .OPER(OPER), .CLEAR_BIT(CLEAR_BIT), .NIB_ACC(NIB_ACC), .NIB_RAM(NIB_RAM),
        .RETIRE(RETIRE));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Issue one instruction, then count cycles until it retires; et of x skips the taken flag
    task automatic run(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2,
        input logic [15:0] npc, input logic [1:0] el, input logic [2:0] ec, input logic et,
        input logic [15:0] etg, input logic etv);
        int n;
        logic r;
        @(negedge CLK);
        INSTR = '{opcode: op, op1: a1, op2: a2, next_pc: npc};
        ISSUE = 1'b1;
        @(negedge CLK);
        n = 1;
        r = RETIRE;
        ISSUE = 1'b0;
        chk({14'h0, LENGTH}, {14'h0, el}, "length");
        chk({15'h0, TARGET_VALID}, {15'h0, etv}, "target valid");
        if (etv)
            chk(TARGET, etg, "target");
        if (et !== 1'bx)
            chk({15'h0, TAKEN}, {15'h0, et}, "taken");
        while (r !== 1'b1 && n < 8)
        begin
            @(negedge CLK);
            n++;
            r = RETIRE;
        end
        chk(16'(n), {13'h0, ec}, "cycles to retire");
        chk({13'h0, CYCLES}, {13'h0, ec}, "cycles");
    endtask

    task automatic t_reset();
        chk({15'h0, READY}, 16'h0001, "ready after reset");
        chk({15'h0, RETIRE}, 16'h0000, "retire after reset");
        chk({14'h0, LENGTH}, 16'h0000, "length after reset");
    endtask

    task automatic t_fixed();
        run(8'h00, 8'h00, 8'h00, 16'h0001, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        run(8'hA5, 8'h00, 8'h00, 16'h0002, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        run(8'h6B, 8'h00, 8'h00, 16'h0003, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        run(8'h4F, 8'h00, 8'h00, 16'h0004, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        run(8'h58, 8'h00, 8'h00, 16'h0005, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        run(8'h67, 8'h00, 8'h00, 16'h0006, 2'h1, 3'h2, 1'bx, 16'h0, 1'b0);
        run(8'h53, 8'h30, 8'h0F, 16'h0009, 2'h3, 3'h3, 1'bx, 16'h0, 1'b0);
        run(8'h33, 8'h00, 8'h00, 16'h000A, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        run(8'hA3, 8'h00, 8'h00, 16'h000B, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        run(8'h90, 8'h12, 8'h34, 16'h000E, 2'h3, 3'h3, 1'bx, 16'h0, 1'b0);
        run(8'h93, 8'h00, 8'h00, 16'h000F, 2'h1, 3'h3, 1'bx, 16'h0, 1'b0);
        for (int k = 0; k < 4; k++)
            run({3'h7, k[1], 2'h0, k[0], 1'b0}, 8'h00, 8'h00, 16'h0010,
                2'h1, 3'h3, 1'bx, 16'h0, 1'b0);
        run(8'h22, 8'h00, 8'h00, 16'h0011, 2'h1, 3'h5, 1'bx, 16'h0, 1'b0);
        run(8'h32, 8'h00, 8'h00, 16'h0012, 2'h1, 3'h5, 1'bx, 16'h0, 1'b0);
    endtask

    task automatic t_jumps();
        run(8'h12, 8'hFE, 8'hDC, 16'h0015, 2'h3, 3'h4, 1'bx, 16'hFEDC, 1'b1);
        run(8'h02, 8'h00, 8'h01, 16'hFFF3, 2'h3, 3'h4, 1'bx, 16'h0001, 1'b1);
        // The next instruction already sits in the following page, so the target must too
        run(8'hE1, 8'h34, 8'h00, 16'h0801, 2'h2, 3'h3, 1'bx, 16'h0F34, 1'b1);
        run(8'h80, 8'hFE, 8'h00, 16'h0010, 2'h2, 3'h3, 1'bx, 16'h000E, 1'b1);
        dp = 16'h1000;
        acc = 8'h20;
        run(8'h73, 8'h00, 8'h00, 16'h0030, 2'h1, 3'h3, 1'bx, 16'h1020, 1'b1);
        run(8'h60, 8'h10, 8'h00, 16'h0040, 2'h2, 3'h2, 1'b0, 16'h0, 1'b0);
        run(8'h75, 8'h30, 8'h55, 16'h0043, 2'h3, 3'h3, 1'bx, 16'h0, 1'b0);
    endtask

    // Busy core ignores a held request, then takes it in the retiring cycle
    task automatic t_stream();
        @(negedge CLK);
        INSTR = '{opcode: 8'h40, op1: 8'h00, op2: 8'h00, next_pc: 16'h0100};
        ISSUE = 1'b1;
        @(negedge CLK);
        chk({15'h0, READY}, 16'h0000, "busy ready");
        INSTR.opcode = 8'h00;
        @(negedge CLK);
        chk({14'h0, LENGTH}, 16'h0002, "refused issue");
        @(negedge CLK);
        chk({15'h0, RETIRE}, 16'h0001, "taken retire");
        @(negedge CLK);
        chk({15'h0, RETIRE}, 16'h0001, "back to back retire");
        chk({14'h0, LENGTH}, 16'h0001, "back to back length");
        ISSUE = 1'b0;
    endtask

    task automatic t_cond();
        carry = 1'b1;
        run(8'h40, 8'h7F, 8'h00, 16'hFFF0, 2'h2, 3'h3, 1'b1, 16'h006F, 1'b1);
        run(8'h50, 8'h10, 8'h00, 16'h0100, 2'h2, 3'h2, 1'b0, 16'h0, 1'b0);
        bit_val = 1'b1;
        run(8'h10, 8'h21, 8'h80, 16'h1000, 2'h3, 3'h4, 1'b1, 16'h0F80, 1'b1);
        chk({15'h0, CLEAR_BIT}, 16'h0001, "bit cleared");
        bit_val = 1'b0;
        run(8'h10, 8'h21, 8'h80, 16'h1000, 2'h3, 3'h3, 1'b0, 16'h0, 1'b0);
        chk({15'h0, CLEAR_BIT}, 16'h0000, "bit kept");
        BANK = 2'h0;
        run(8'hB6, 8'h02, 8'h05, 16'h0200, 2'h3, 3'h4, 1'b0, 16'h0, 1'b0);
        run(8'hB6, 8'h03, 8'h05, 16'h0200, 2'h3, 3'h5, 1'b1, 16'h0205, 1'b1);
        run(8'hD8, 8'h04, 8'h00, 16'h0300, 2'h2, 3'h2, 1'b0, 16'h0, 1'b0);
        run(8'hD9, 8'hFC, 8'h00, 16'h0300, 2'h2, 3'h3, 1'b1, 16'h02FC, 1'b1);
    endtask

    task automatic t_operands();
        BANK = 2'h2;
        run(8'h6B, 8'h00, 8'h00, 16'h0001, 2'h1, 3'h1, 1'bx, 16'h0, 1'b0);
        chk({8'h0, OPER.bank_register}, 16'h0013, "bank register");
        run(8'h67, 8'h00, 8'h00, 16'h0001, 2'h1, 3'h2, 1'bx, 16'h0, 1'b0);
        chk({8'h0, OPER.indirect_pointer_operand}, 16'h0012, "pointer");
        run(8'h65, 8'h7F, 8'h00, 16'h0002, 2'h2, 3'h2, 1'bx, 16'h0, 1'b0);
        chk({7'h0, OPER.direct_addr, OPER.direct_is_sfr}, 16'h00FE, "ram half");
        run(8'h65, 8'h80, 8'h00, 16'h0002, 2'h2, 3'h2, 1'bx, 16'h0, 1'b0);
        chk({7'h0, OPER.direct_addr, OPER.direct_is_sfr}, 16'h0101, "register half");
        BANK = 2'h0;
        acc = 8'hA3;
        run(8'hD6, 8'h00, 8'h00, 16'h0001, 2'h1, 3'h2, 1'bx, 16'h0, 1'b0);
        chk({NIB_ACC, NIB_RAM}, 16'hA203, "nibble exchange");
    endtask

    initial
    begin
        #200000;
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (10) @(negedge CLK);
        RST_N = 1'b1;
        @(negedge CLK);
        t_reset();
        t_fixed();
        t_jumps();
        t_cond();
        t_operands();
        t_stream();
        summarize();
    end
endmodule
